//--- hw/fcb_flash_cmd.sv
// Flash command front end: command object array, launch, lock config, backdoor unlock.
// Assumes an APB4 master on clk_i and flash-side inputs driven on the same clock.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module fcb_flash_cmd import fcb_pkg::*; (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [63:0] backdoor_keys_i,
	input wire logic [7:0] sec_byte_i,
	input wire logic sec_dbl_err_i,
	output logic [7:0] lock_cfg_o,
	output logic secure_o,
	output logic backdoor_en_o,
	output logic nvm_read_block_o,
	output logic irq_o
);
	fcb_regs_t q;
	fcb_regs_t n;
	logic [IRQ_W-1:0] ev;
	logic [7:0] widx;
	logic wr;
	logic launch;
	logic match;
	logic [7:0] cmd;
	logic [17:0] addr;
	logic [63:0] cand;

	function automatic logic [7:0] reg_idx(input logic [11:0] a);
		reg_idx = {2'h0, a[7:2]};
	endfunction : reg_idx

	function automatic logic is_prot(input logic [1:0] p, input logic [17:0] a);
		is_prot = p[1] || (p[0] && (a >= PROT_HIGH_BASE));
	endfunction : is_prot

	assign widx = reg_idx(paddr_i);
	assign wr = psel_i && penable_i && pwrite_i;
	// Word 0 hi is the code, word 0 lo holds address 17:16, word 1 the rest
	assign cmd = q.ccob[0][15:8];
	assign addr = {q.ccob[0][1:0], q.ccob[1]};
	// Candidate keys sit in words 1 to 4
	assign cand = {q.ccob[1], q.ccob[2], q.ccob[3], q.ccob[4]};

	fcb_key_check u_keys (
		.cand_keys_i(cand),
		.stored_keys_i(backdoor_keys_i),
		.lock_cfg_i(q.lock),
		.backdoor_en_o(backdoor_en_o),
		.secure_o(secure_o),
		.match_o(match)
	);

	always_comb begin
		n = q;
		ev = '0;
		launch = 1'b0;
		// Read data and error are prepared in the setup phase
		if (psel_i && !penable_i) begin
			n.slverr = 1'b0;
			n.rdata = 32'h0;
			if (widx == IDX_LOCK) begin
				n.rdata = {24'h0, q.lock};
			end else if (widx == IDX_INDEX) begin
				n.rdata = {29'h0, q.index};
			end else if (widx == IDX_STAT) begin
				n.rdata[STAT_DONE_BIT] = q.done;
				n.rdata[STAT_ACCERR_BIT] = q.accerr;
				n.rdata[STAT_PVIOL_BIT] = q.pviol;
			end else if (widx == IDX_CCOB) begin
				// Unimplemented words read as zero
				if (q.index <= CCOB_LAST) begin
					n.rdata = {16'h0, q.ccob[q.index]};
				end
			end else if (widx == IDX_PROT) begin
				n.rdata = {30'h0, q.prot};
			end else if (widx == IDX_IRQ_ST) begin
				n.rdata = {29'h0, q.irq_st};
			end else if (widx == IDX_IRQ_MASK) begin
				n.rdata = {29'h0, q.irq_mask};
			end else begin
				n.slverr = 1'b1;
			end
		end
		if (wr) begin
			if (widx == IDX_INDEX) begin
				if (pstrb_i[0]) begin
					n.index = pwdata_i[IDX_W-1:0];
				end
			end else if (widx == IDX_CCOB) begin
				// Locked while running; words 6 and 7 do not exist
				if (q.done && q.state == ST_IDLE && q.index <= CCOB_LAST) begin
					if (pstrb_i[0]) begin
						n.ccob[q.index][7:0] = pwdata_i[7:0];
					end
					if (pstrb_i[1]) begin
						n.ccob[q.index][15:8] = pwdata_i[15:8];
					end
				end
			end else if (widx == IDX_STAT) begin
				if (pstrb_i[0]) begin
					if (pwdata_i[STAT_ACCERR_BIT]) begin
						n.accerr = 1'b0;
					end
					if (pwdata_i[STAT_PVIOL_BIT]) begin
						n.pviol = 1'b0;
					end
					launch = pwdata_i[STAT_DONE_BIT] && q.done && q.state == ST_IDLE;
				end
			end else if (widx == IDX_PROT) begin
				if (pstrb_i[0]) begin
					n.prot = pwdata_i[1:0];
				end
			end else if (widx == IDX_IRQ_ST) begin
				if (pstrb_i[0]) begin
					n.irq_st = q.irq_st & ~pwdata_i[IRQ_W-1:0];
				end
			end else if (widx == IDX_IRQ_MASK) begin
				if (pstrb_i[0]) begin
					n.irq_mask = pwdata_i[IRQ_W-1:0];
				end
			end
		end
		case (q.state)
			ST_LOAD: begin
				// Security byte captured once after reset release
				if (sec_dbl_err_i) begin
					n.lock = LOCK_ALL;
				end else begin
					n.lock = sec_byte_i;
				end
				n.state = ST_IDLE;
			end
			ST_IDLE: begin
				if (launch) begin
					n.done = 1'b0;
					n.cnt = EXEC_CYCLES - 8'h01;
					n.state = ST_EXEC;
					if (cmd == CMD_VERIFY_KEYS) begin
						if (backdoor_en_o) begin
							n.cnt = VERIFY_CYCLES - 8'h01;
							n.state = ST_VERIFY;
						end else begin
							n.accerr = 1'b1;
							n.cnt = 8'h00;
						end
					end else if ((cmd == CMD_PROGRAM || cmd == CMD_ERASE) && is_prot(q.prot, addr)) begin
						// Rejected without touching the array
						n.pviol = 1'b1;
						n.cnt = 8'h00;
						ev[IRQ_PVIOL] = 1'b1;
					end
				end
			end
			ST_VERIFY: begin
				if (q.cnt == 8'h00) begin
					if (match) begin
						n.lock[LVL_HI:LVL_LO] = LVL_UNSEC;
					end else begin
						ev[IRQ_KEYFAIL] = 1'b1;
					end
					n.ccob[CCOB_LAST] = {15'h0, match};
					n.done = 1'b1;
					ev[IRQ_DONE] = 1'b1;
					n.state = ST_IDLE;
				end else begin
					n.cnt = q.cnt - 8'h01;
				end
			end
			ST_EXEC: begin
				if (q.cnt == 8'h00) begin
					n.done = 1'b1;
					ev[IRQ_DONE] = 1'b1;
					n.state = ST_IDLE;
				end else begin
					n.cnt = q.cnt - 8'h01;
				end
			end
			default: begin
				n.state = ST_IDLE;
			end
		endcase
		// Hardware events win over a same-cycle clear
		n.irq_st = n.irq_st | ev;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			q <= REGS_RESET;
		end else begin
			q <= n;
		end
	end

	assign prdata_o = q.rdata;
	assign pslverr_o = q.slverr;
	assign pready_o = psel_i && penable_i;
	assign lock_cfg_o = q.lock;
	// Array reads return invalid data while keys are compared
	assign nvm_read_block_o = q.state == ST_VERIFY;
	assign irq_o = |(q.irq_st & q.irq_mask);

	logic rd_setup;
	logic bad_stored;

	assign rd_setup = psel_i && !penable_i && !pwrite_i;
	assign bad_stored = (backdoor_keys_i[15:0] == KEY_BAD_LO) || (backdoor_keys_i[15:0] == KEY_BAD_HI);

	chk_unlock_sec: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(q.state == ST_VERIFY && q.cnt == 8'h00 && match) |=> (lock_cfg_o[1:0] == 2'h2 && !secure_o))
		else $error("Key match did not unsecure");

	chk_mismatch_keep: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(q.state == ST_VERIFY && q.cnt == 8'h00 && !match) |=> (lock_cfg_o[1:0] == $past(lock_cfg_o[1:0])))
		else $error("Mismatch changed protection bits");

	chk_blank_key: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		bad_stored |-> !match)
		else $error("Blank stored key produced a match");

	chk_read_block: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(q.state == ST_IDLE && launch && cmd == CMD_VERIFY_KEYS && backdoor_en_o)
		|=> nvm_read_block_o [*4] ##1 (!nvm_read_block_o && q.done))
		else $error("Read block window wrong length");

	chk_launch_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(wr && widx == IDX_STAT && pstrb_i[0] && pwdata_i[7] && q.done && q.state == ST_IDLE)
		|=> !q.done ##[1:16] q.done)
		else $error("Launch did not clear then restore complete flag");

	chk_param_lock: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(wr && widx == IDX_CCOB && !q.done && q.state == ST_EXEC) |=> (q.ccob == $past(q.ccob)))
		else $error("Parameter word changed while busy");

	chk_unimpl_read: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(rd_setup && widx == IDX_CCOB && q.index > 3'h5) |=> (prdata_o == 32'h0))
		else $error("Unimplemented word read nonzero");

	chk_index_read: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(rd_setup && widx == IDX_INDEX) |=> (prdata_o[31:3] == 29'h0 && prdata_o[2:0] == $past(q.index)))
		else $error("Index register read wrong");

	chk_dbl_err: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(q.state == ST_LOAD && sec_dbl_err_i) |=> (lock_cfg_o == 8'hff && !backdoor_en_o && secure_o))
		else $error("Double-bit error did not lock all bits");

	chk_prot_reject: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(q.state == ST_IDLE && launch && cmd == CMD_PROGRAM && is_prot(q.prot, addr))
		|=> (q.pviol && !q.done) ##1 (q.done && q.irq_st[IRQ_PVIOL]))
		else $error("Protected program not rejected");

	// Further rule checks; expected values come from $past, $stable or literals
	chk_verify_lock: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(wr && widx == IDX_CCOB && q.state == ST_VERIFY) |=> (q.ccob[4:0] == $past(q.ccob[4:0])))
		else $error("Parameter word changed during key compare");

	chk_unimpl_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(wr && widx == IDX_CCOB && q.index > CCOB_LAST) |=> $stable(q.ccob[4:0]))
		else $error("Write to unimplemented word changed the array");

	chk_byte_lane: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(wr && widx == IDX_CCOB && pstrb_i[1:0] == 2'b01 && q.state == ST_IDLE && q.index <= CCOB_LAST)
		|=> (q.ccob[$past(q.index)] == {$past(q.ccob[q.index][15:8]), $past(pwdata_i[7:0])}))
		else $error("Low byte lane write wrong");

	chk_backdoor_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(q.state == ST_IDLE && launch && cmd == CMD_VERIFY_KEYS && !backdoor_en_o)
		|=> (q.accerr && !nvm_read_block_o && lock_cfg_o == $past(lock_cfg_o)) ##1 q.done)
		else $error("Disabled backdoor did not refuse key compare");

	chk_done_event: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		$rose(q.done) |-> q.irq_st[IRQ_DONE])
		else $error("Completion did not raise done event");

	chk_event_sticky: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(q.irq_st[IRQ_DONE] && !(wr && widx == IDX_IRQ_ST && pstrb_i[0])) |=> q.irq_st[IRQ_DONE])
		else $error("Done event cleared without a write");

	chk_lock_stable: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(q.state == ST_IDLE || q.state == ST_EXEC) |=> $stable(lock_cfg_o))
		else $error("Lock configuration changed outside load or unlock");

	chk_load_byte: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(q.state == ST_LOAD && !sec_dbl_err_i) |=> (lock_cfg_o == $past(sec_byte_i)))
		else $error("Security byte not loaded after reset");

	chk_prot_whole: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(q.state == ST_IDLE && launch && (cmd == CMD_PROGRAM || cmd == CMD_ERASE) && q.prot[1])
		|=> (q.pviol && q.state == ST_EXEC && q.cnt == 8'h00))
		else $error("Whole-array protection not applied");

	chk_busy_relaunch: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(wr && widx == IDX_STAT && pstrb_i[0] && pwdata_i[STAT_DONE_BIT]
		&& q.state == ST_EXEC && q.cnt != 8'h00)
		|=> (!q.done && q.cnt == $past(q.cnt) - 8'h01))
		else $error("Launch while busy restarted the command");

	chk_index_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(wr && widx == IDX_INDEX && pstrb_i[0]) |=> (q.index == $past(pwdata_i[IDX_W-1:0])))
		else $error("Index register write not taken");

	chk_keyfail_event: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(q.state == ST_VERIFY && q.cnt == 8'h00 && !match)
		|=> (q.irq_st[IRQ_KEYFAIL] && q.ccob[CCOB_LAST] == 16'h0000))
		else $error("Key mismatch not reported");

	cov_unlock: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		q.state == ST_VERIFY ##1 (q.state == ST_IDLE && !secure_o));

	cov_keyfail: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		q.state == ST_VERIFY ##1 q.irq_st[IRQ_KEYFAIL]);

	cov_exec_done: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		q.state == ST_EXEC ##1 (q.state == ST_IDLE && irq_o));

	cov_locked_write: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		wr && widx == IDX_CCOB && !q.done);

	cov_dbl_err: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		q.state == ST_LOAD && sec_dbl_err_i);
endmodule : fcb_flash_cmd

//--- hw/fcb_pkg.sv
// Constants, state and register layout for the flash command front end.
// Assumes a 50 MHz system bus clock and an APB master with 32-bit data.
package fcb_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_LOCK = 8'h01;
	localparam logic [7:0] IDX_INDEX = 8'h02;
	localparam logic [7:0] IDX_STAT = 8'h06;
	localparam logic [7:0] IDX_CCOB = 8'h0a;
	localparam logic [7:0] IDX_PROT = 8'h0b;
	localparam logic [7:0] IDX_IRQ_ST = 8'h0c;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h0d;
	// Status register bit positions
	localparam int STAT_DONE_BIT = 7;
	localparam int STAT_ACCERR_BIT = 5;
	localparam int STAT_PVIOL_BIT = 4;
	// Interrupt status / mask bit positions
	localparam int IRQ_DONE = 0;
	localparam int IRQ_PVIOL = 1;
	localparam int IRQ_KEYFAIL = 2;
	localparam int IRQ_W = 3;
	// Lock configuration fields
	localparam int KEY_EN_HI = 7;
	localparam int KEY_EN_LO = 6;
	localparam int LVL_HI = 1;
	localparam int LVL_LO = 0;
	localparam logic [1:0] KEY_EN_ON = 2'h2;
	localparam logic [1:0] LVL_UNSEC = 2'h2;
	localparam logic [7:0] LOCK_ALL = 8'hff;
	// Command object geometry and blank stored key values
	localparam int CCOB_WORDS = 6;
	localparam int IDX_W = 3;
	localparam logic [IDX_W-1:0] CCOB_LAST = 3'h5;
	localparam logic [15:0] KEY_BAD_LO = 16'h0000;
	localparam logic [15:0] KEY_BAD_HI = 16'hffff;
	// Command codes (arbitrary choices)
	localparam logic [7:0] CMD_VERIFY_KEYS = 8'h0c;
	localparam logic [7:0] CMD_PROGRAM = 8'h06;
	localparam logic [7:0] CMD_ERASE = 8'h0a;
	// Protection: bit0 guards the top region, bit1 the whole array
	localparam logic [1:0] PROT_RESET = 2'h0;
	localparam logic [17:0] PROT_HIGH_BASE = 18'h3f800;
	// Execution lengths in bus clock cycles
	localparam logic [7:0] VERIFY_CYCLES = 8'h04;
	localparam logic [7:0] EXEC_CYCLES = 8'h10;

	typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_VERIFY, ST_EXEC} fcb_state_t;

	typedef struct packed {
		fcb_state_t state;
		logic [7:0] cnt;
		logic [IDX_W-1:0] index;
		logic [CCOB_WORDS-1:0][15:0] ccob;
		logic [7:0] lock;
		logic done;
		logic accerr;
		logic pviol;
		logic [1:0] prot;
		logic [IRQ_W-1:0] irq_st;
		logic [IRQ_W-1:0] irq_mask;
		logic [31:0] rdata;
		logic slverr;
	} fcb_regs_t;

	localparam fcb_regs_t REGS_RESET = '{state: ST_LOAD, cnt: 8'h00, index: 3'h0,
		ccob: '0, lock: LOCK_ALL, done: 1'b1, accerr: 1'b0, pviol: 1'b0,
		prot: PROT_RESET, irq_st: '0, irq_mask: '0, rdata: 32'h0, slverr: 1'b0};
endpackage : fcb_pkg

//--- hw/fcb_key_check.sv
// Backdoor key comparison and lock configuration decode.
// Purely combinational; keys come from the flash configuration area.
`timescale 1ns/1ps
module fcb_key_check import fcb_pkg::*; (
	input wire logic [63:0] cand_keys_i,
	input wire logic [63:0] stored_keys_i,
	input wire logic [7:0] lock_cfg_i,
	output logic backdoor_en_o,
	output logic secure_o,
	output logic match_o
);
	function automatic logic key_bad(input logic [15:0] k);
		key_bad = (k == KEY_BAD_LO) || (k == KEY_BAD_HI);
	endfunction : key_bad

	logic any_bad;

	always_comb begin
		any_bad = 1'b0;
		for (int i = 0; i < 4; i++) begin
			any_bad = any_bad | key_bad(stored_keys_i[i*16 +: 16]);
		end
	end

	// Only 10 enables the backdoor; 01 is the preferred off code
	assign backdoor_en_o = lock_cfg_i[KEY_EN_HI:KEY_EN_LO] == KEY_EN_ON;
	// Only 10 is unsecured; all other codes are secured
	assign secure_o = lock_cfg_i[LVL_HI:LVL_LO] != LVL_UNSEC;
	// All four words must match and no stored key may be blank
	assign match_o = (cand_keys_i == stored_keys_i) && !any_bad;
endmodule : fcb_key_check

//--- bench/tb.sv
// Self-checking bench for the flash command front end, driven over APB.
// Assumes the design instantiated as i_dut with its inline checks; no partner model.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb import fcb_pkg::*;;
	logic clk_i = 0, reset_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, sec_dbl_err_i = 0;
	logic [11:0] paddr_i = 0;
	logic [31:0] pwdata_i = 0, prdata_o, rd;
	logic [3:0] pstrb_i = 0;
	logic [63:0] backdoor_keys_i = 0;
	logic [7:0] sec_byte_i = 0, lock_cfg_o;
	logic pready_o, pslverr_o, secure_o, backdoor_en_o, nvm_read_block_o, irq_o, err;
	int n_errors = 0, samples_checked = 0;
	localparam logic [63:0] KEYS = 64'h1234_5678_9abc_def0;

	always #10 clk_i = ~clk_i;

	fcb_flash_cmd i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .backdoor_keys_i(backdoor_keys_i),
		.sec_byte_i(sec_byte_i), .sec_dbl_err_i(sec_dbl_err_i), .lock_cfg_o(lock_cfg_o),
		.secure_o(secure_o), .backdoor_en_o(backdoor_en_o), .nvm_read_block_o(nvm_read_block_o),
		.irq_o(irq_o));

	task end_of_test;
		if (n_errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	// One APB transfer; holds the request until pready is sampled high
	task apb(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s);
		int k;
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= {4'h0, idx[5:0], 2'h0};
		pwdata_i <= d;
		pstrb_i <= w ? s : 4'h0;
		@(posedge clk_i);
		penable_i <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (pready_o !== 1'b1 && k < 20);
		if (pready_o !== 1'b1) begin
			n_errors++;
			end_of_test;
		end
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s = 4'hf);
		apb(1'b1, idx, d, s);
	endtask : wr

	task rdr(input logic [7:0] idx);
		apb(1'b0, idx, 32'h0, 4'h0);
	endtask : rdr

	task word(input logic [2:0] i, input logic [15:0] v);
		wr(IDX_INDEX, {29'h0, i});
		wr(IDX_CCOB, {16'h0, v}, 4'h3);
	endtask : word

	task rd_word(input logic [2:0] i);
		wr(IDX_INDEX, {29'h0, i});
		rdr(IDX_CCOB);
	endtask : rd_word

	task do_reset(input logic [7:0] sb, input logic de);
		@(posedge clk_i);
		reset_n_i <= 1'b0;
		sec_byte_i <= sb;
		sec_dbl_err_i <= de;
		repeat (12) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		#1;
	endtask : do_reset

	task wait_done;
		int k;
		k = 0;
		do begin
			rdr(IDX_STAT);
			k++;
		end while (rd[STAT_DONE_BIT] !== 1'b1 && k < 50);
		if (rd[STAT_DONE_BIT] !== 1'b1) begin
			n_errors++;
			end_of_test;
		end
	endtask : wait_done

	task launch;
		wr(IDX_STAT, 32'h80, 4'h1);
	endtask : launch

	task t_reset_regs;
		for (int v = 0; v < 4; v++) begin
			do_reset({v[1:0], 4'hf, v[1:0]}, 1'b0);
			`CHK(lock_cfg_o, {v[1:0], 4'hf, v[1:0]})
			`CHK(backdoor_en_o, v == 2)
			`CHK(secure_o, v != 2)
		end
		do_reset(8'h82, 1'b1);
		`CHK(lock_cfg_o, 8'hff)
		`CHK({secure_o, backdoor_en_o}, 2'b10)
		do_reset(8'h81, 1'b0);
		rdr(IDX_INDEX);
		`CHK(rd[7:0], 8'h00)
		wr(IDX_INDEX, 32'hff);
		rdr(IDX_INDEX);
		`CHK(rd[7:0], 8'h07)
		wr(IDX_LOCK, 32'h0);
		rdr(IDX_LOCK);
		`CHK(rd[7:0], 8'h81)
		rdr(8'h3f);
		`CHK(err, 1'b1)
	endtask : t_reset_regs

	task t_array;
		for (int i = 0; i < 8; i++)
			word(i[2:0], 16'(16'h1111 * (i + 1)));
		for (int i = 0; i < 8; i++) begin
			rd_word(i[2:0]);
			`CHK(rd[15:0], (i < 6) ? 16'h1111 * (i + 1) : 16'h0000)
		end
		wr(IDX_INDEX, 32'h0);
		wr(IDX_CCOB, 32'h0000abcd, 4'h1);
		rdr(IDX_CCOB);
		`CHK(rd[15:0], 16'h11cd)
	endtask : t_array

	task t_program;
		word(0, {CMD_PROGRAM, 8'h00});
		word(1, 16'h0100);
		launch;
		rdr(IDX_STAT);
		`CHK(rd[STAT_DONE_BIT], 1'b0)
		launch;
		word(1, 16'hbeef);
		rdr(IDX_CCOB);
		`CHK(rd[15:0], 16'h0100)
		wait_done;
		word(1, 16'hbeef);
		rdr(IDX_CCOB);
		`CHK(rd[15:0], 16'hbeef)
	endtask : t_program

	task t_protect(input logic [7:0] code);
		wr(IDX_PROT, 32'h1);
		word(0, {code, 8'h03});
		word(1, 16'hf800);
		launch;
		wait_done;
		`CHK(rd[STAT_PVIOL_BIT], 1'b1)
		wr(IDX_STAT, 32'h10, 4'h1);
		word(0, {code, 8'h00});
		launch;
		wait_done;
		`CHK(rd[STAT_PVIOL_BIT], 1'b0)
		wr(IDX_PROT, 32'h2);
		launch;
		wait_done;
		`CHK(rd[STAT_PVIOL_BIT], 1'b1)
		wr(IDX_STAT, 32'h10, 4'h1);
	endtask : t_protect

	task verify(input logic [63:0] st, input logic [63:0] cand, input logic blk);
		@(posedge clk_i);
		backdoor_keys_i <= st;
		word(0, {CMD_VERIFY_KEYS, 8'h00});
		for (int j = 1; j < 5; j++)
			word(j[2:0], cand[16 * (4 - j) +: 16]);
		launch;
		#1;
		`CHK(nvm_read_block_o, blk)
		wait_done;
		rd_word(5);
	endtask : verify

	task t_keys;
		wr(IDX_IRQ_ST, 32'h7);
		verify(KEYS, KEYS ^ 64'h1, 1'b1);
		`CHK(rd[15:0], 16'h0000)
		`CHK({secure_o, lock_cfg_o[1:0], irq_o}, 4'b1010)
		rdr(IDX_IRQ_ST);
		`CHK(rd[2:0], 3'b101)
		wr(IDX_IRQ_MASK, 32'h7);
		rdr(IDX_IRQ_MASK);
		`CHK(irq_o, 1'b1)
		wr(IDX_IRQ_ST, 32'h7);
		rdr(IDX_IRQ_ST);
		`CHK({rd[2:0], irq_o}, 4'b0000)
		verify({16'h0000, KEYS[47:0]}, {16'h0000, KEYS[47:0]}, 1'b1);
		`CHK({rd[15:0], secure_o}, 17'h00001)
		verify({KEYS[63:16], 16'hffff}, {KEYS[63:16], 16'hffff}, 1'b1);
		`CHK({rd[15:0], secure_o}, 17'h00001)
		verify(KEYS, KEYS, 1'b1);
		`CHK(rd[15:0], 16'h0001)
		`CHK({secure_o, lock_cfg_o[1:0]}, 3'b010)
		do_reset(8'h41, 1'b0);
		verify(KEYS, KEYS, 1'b0);
		`CHK({rd[15:0], secure_o}, 17'h00001)
		rdr(IDX_STAT);
		`CHK({rd[STAT_ACCERR_BIT], secure_o}, 2'b11)
	endtask : t_keys

	initial begin
		repeat (12) @(posedge clk_i);
		t_reset_regs;
		t_array;
		t_program;
		t_protect(CMD_PROGRAM);
		t_protect(CMD_ERASE);
		t_keys;
		end_of_test;
	end
endmodule : tb
